// ==== hdl/multibuffer_serial_port_map.vh ====
// field positions, reset values and timing counts of the buffered serial port
`ifndef MULTIBUFFER_SERIAL_PORT_MAP_VH
`define MULTIBUFFER_SERIAL_PORT_MAP_VH

// global control word
`define GCR_CONTROLLER_BIT   0

// word format word
`define FMT_LEN_MSB          4
`define FMT_LEN_LSB          0
`define FMT_PS_MSB           15
`define FMT_PS_LSB           8
`define FMT_PHASE_BIT        16
`define FMT_POLARITY_BIT     17

// per-entry control and status fields
`define CTRL_FMT_SEL_BIT     0
`define CTRL_HOLD_BIT        1
`define STAT_DONE_BIT        0
`define STAT_ABORT_BIT       1

// word length limits
`define WORD_LEN_MIN         5'd2
`define WORD_LEN_MAX         5'd16

// buffer memory and fifo shape
`define BUF_ENTRIES          256
`define BUF_AW               8
`define FIFO_DEPTH           32
`define FIFO_AW              5
`define FIFO_WIDTH           40

// chip select lead and lag base counts
`define LEAD_BASE            9'd2
`define LAG_BASE             9'd1

// timing: system clock and fastest allowed serial clock
`define CLK_PERIOD_NS        100
`define SCLK_MIN_PERIOD_NS   25
`define SCLK_MIN_CYC         ((`SCLK_MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// engine states
`define ST_IDLE              3'd0
`define ST_LEAD              3'd1
`define ST_SHIFT             3'd2
`define ST_LAG               3'd3
`define ST_DONE              3'd4

// reset values
`define RST_STATUS           16'h0000
`define RST_CS_N             1'b1

`endif

// ==== hdl/word_fifo.v ====
// synchronous word fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter WIDTH = 40,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk_in,
   input  wire             sys_rst_in,
   input  wire             in_valid_in,
   output wire             in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   output wire             out_valid_out,
   input  wire             out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;
   wire            push;
   wire            pop;

   // honest full and empty from the fill count
   assign in_ready_out  = (count_ff != DEPTH[AW:0]);
   assign out_valid_out = (count_ff != {(AW+1){1'b0}});
   assign out_data_out  = mem_ff[rd_ptr_ff];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   // pointers and count
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end

   // storage
   always @(posedge clk_in) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_in;
      end
   end
endmodule // word_fifo
`default_nettype wire

// ==== hdl/transfer_buffer_ram.v ====
// buffer memory: per entry transmit, receive, control and status fields
`timescale 1ns/1ps
`default_nettype none
`include "multibuffer_serial_port_map.vh"
module transfer_buffer_ram (
   input  wire        clk_in,
   input  wire        sys_rst_in,
   input  wire        sw_we_in,
   input  wire [7:0]  sw_wr_addr_in,
   input  wire [15:0] sw_tx_in,
   input  wire [15:0] sw_ctrl_in,
   input  wire [7:0]  sw_rd_addr_in,
   input  wire        sw_stat_clr_in,
   output reg  [15:0] sw_rx_out,
   output reg  [15:0] sw_stat_out,
   input  wire [7:0]  hw_rd_addr_in,
   output wire [15:0] hw_tx_out,
   output wire [15:0] hw_ctrl_out,
   input  wire        hw_we_in,
   input  wire [7:0]  hw_wr_addr_in,
   input  wire [15:0] hw_rx_in,
   input  wire [15:0] hw_stat_in
);
   reg [15:0] tx_mem_ff   [0:`BUF_ENTRIES-1];
   reg [15:0] rx_mem_ff   [0:`BUF_ENTRIES-1];
   reg [15:0] ctrl_mem_ff [0:`BUF_ENTRIES-1];
   reg [15:0] stat_mem_ff [0:`BUF_ENTRIES-1];
   integer    i;

   assign hw_tx_out   = tx_mem_ff[hw_rd_addr_in];
   assign hw_ctrl_out = ctrl_mem_ff[hw_rd_addr_in];

   // software side writes transmit and control fields
   always @(posedge clk_in) begin
      if (sw_we_in) begin
         tx_mem_ff[sw_wr_addr_in]   <= sw_tx_in;
         ctrl_mem_ff[sw_wr_addr_in] <= sw_ctrl_in;
      end
      if (hw_we_in) begin
         rx_mem_ff[hw_wr_addr_in] <= hw_rx_in;
      end
   end

   // status: engine write wins over software clear
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         for (i = 0; i < `BUF_ENTRIES; i = i + 1) begin
            stat_mem_ff[i] <= `RST_STATUS;
         end
      end else begin
         if (sw_stat_clr_in) begin
            stat_mem_ff[sw_rd_addr_in] <= `RST_STATUS;
         end
         if (hw_we_in) begin
            stat_mem_ff[hw_wr_addr_in] <= hw_stat_in;
         end
      end
   end

   // registered software read port
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         sw_rx_out   <= 16'h0000;
         sw_stat_out <= `RST_STATUS;
      end else begin
         sw_rx_out   <= rx_mem_ff[sw_rd_addr_in];
         sw_stat_out <= stat_mem_ff[sw_rd_addr_in];
      end
   end
endmodule // transfer_buffer_ram
`default_nettype wire

// ==== hdl/multibuffer_serial_port.v ====
// buffered serial port: group loader, word fifo, shift engine and pin muxing
`timescale 1ns/1ps
`default_nettype none
`include "multibuffer_serial_port_map.vh"
module multibuffer_serial_port (
   input  wire        clk_in,
   input  wire        sys_rst_in,
   input  wire [31:0] global_control_reg_in,
   input  wire [31:0] word_format0_reg_in,
   input  wire [31:0] word_format1_reg_in,
   input  wire [7:0]  select_lead_delay_in,
   input  wire [7:0]  select_lag_delay_in,
   input  wire        buf_wr_en_in,
   input  wire [7:0]  buf_wr_addr_in,
   input  wire [15:0] buf_wr_tx_in,
   input  wire [15:0] buf_wr_ctrl_in,
   input  wire [7:0]  buf_rd_addr_in,
   input  wire        buf_stat_clr_in,
   output wire [15:0] buf_rd_rx_out,
   output wire [15:0] buf_rd_stat_out,
   input  wire [7:0]  group_first_in,
   input  wire [7:0]  group_last_in,
   input  wire        group_start_in,
   input  wire [3:0]  gpio_en_in,
   input  wire [3:0]  gpio_dir_in,
   input  wire [3:0]  gpio_dout_in,
   output reg  [3:0]  gpio_din_out,
   input  wire        serial_clock_pin_in,
   output reg         serial_clock_pin_out,
   output reg         serial_clock_pin_oe_out,
   input  wire        controller_out_line_in,
   output reg         controller_out_line_out,
   output reg         controller_out_line_oe_out,
   input  wire        controller_in_line_in,
   output reg         controller_in_line_out,
   output reg         controller_in_line_oe_out,
   input  wire        chip_select_n_in,
   output reg         chip_select_n_out,
   output reg         chip_select_n_oe_out,
   output reg         busy_out,
   output reg         group_done_out
);

   // shortest legal serial clock period, sized to the period counter
   localparam [8:0] MIN_PERIOD = `SCLK_MIN_CYC;

   // ****************************************
   // helper functions
   // ****************************************

   // clamp the length field into the legal range
   function [4:0] eff_len;
      input [4:0] f;
      begin
         if (f < `WORD_LEN_MIN) begin
            eff_len = `WORD_LEN_MIN;
         end else if (f > `WORD_LEN_MAX) begin
            eff_len = `WORD_LEN_MAX;
         end else begin
            eff_len = f;
         end
      end
   endfunction

   // serial clock period in system cycles from the prescale field
   function [8:0] sclk_period;
      input [7:0] ps;
      reg   [8:0] p;
      begin
         p = 9'd0;
         if (ps == 8'h00) begin
            p = 9'd2;
         end else begin
            p = {1'b0, ps} + 9'd1;
         end
         if (p < MIN_PERIOD) begin
            p = MIN_PERIOD;
         end
         sclk_period = p;
      end
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   reg  [2:0]  state_ff;
   reg  [15:0] sh_ff;
   reg  [15:0] rx_ff;
   reg  [7:0]  idx_ff;
   reg  [4:0]  len_ff;
   reg         pol_ff;
   reg         pha_ff;
   reg         hold_ff;
   reg  [7:0]  half_a_ff;
   reg  [7:0]  half_b_ff;
   reg  [8:0]  cnt_ff;
   reg  [5:0]  ecnt_ff;
   reg         sclk_ff;
   reg         cs_n_ff;
   reg         abort_ff;
   reg         sclk_prev_ff;
   reg         ld_active_ff;
   reg  [7:0]  ld_idx_ff;
   reg  [7:0]  ld_last_ff;
   wire        ctrl_mode;
   wire [15:0] ram_tx;
   wire [15:0] ram_ctrl;
   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire [39:0] fifo_out_data;
   wire        fifo_pop;
   wire [31:0] sel_fmt;
   wire [4:0]  new_len;
   wire [8:0]  new_period;
   wire [7:0]  new_half_a;
   wire        do_edge_c;
   wire        do_edge_p;
   wire        do_edge;
   wire        is_sample;
   wire        is_shift;
   wire        din;
   wire        last_sample;
   wire        hw_we;
   wire [15:0] hw_stat;

   // mode select from global control bit 0
   assign ctrl_mode = global_control_reg_in[`GCR_CONTROLLER_BIT];

   // ****************************************
   // buffer memory and group loader
   // ****************************************

   transfer_buffer_ram u_ram (
      .clk_in         (clk_in),
      .sys_rst_in     (sys_rst_in),
      .sw_we_in       (buf_wr_en_in),
      .sw_wr_addr_in  (buf_wr_addr_in),
      .sw_tx_in       (buf_wr_tx_in),
      .sw_ctrl_in     (buf_wr_ctrl_in),
      .sw_rd_addr_in  (buf_rd_addr_in),
      .sw_stat_clr_in (buf_stat_clr_in),
      .sw_rx_out      (buf_rd_rx_out),
      .sw_stat_out    (buf_rd_stat_out),
      .hw_rd_addr_in  (ld_idx_ff),
      .hw_tx_out      (ram_tx),
      .hw_ctrl_out    (ram_ctrl),
      .hw_we_in       (hw_we),
      .hw_wr_addr_in  (idx_ff),
      .hw_rx_in       (rx_ff),
      .hw_stat_in     (hw_stat)
   );

   // loader feeds the fifo, stalls while it is full
   word_fifo #(
      .WIDTH (`FIFO_WIDTH),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .clk_in        (clk_in),
      .sys_rst_in    (sys_rst_in),
      .in_valid_in   (ld_active_ff),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    ({ld_idx_ff, ram_ctrl, ram_tx}),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_pop),
      .out_data_out  (fifo_out_data)
   );

   // walk one group of consecutive entries
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         ld_active_ff <= 1'b0;
         ld_idx_ff    <= 8'h00;
         ld_last_ff   <= 8'h00;
      end else if (!ld_active_ff) begin
         if (group_start_in) begin
            ld_active_ff <= 1'b1;
            ld_idx_ff    <= group_first_in;
            ld_last_ff   <= group_last_in;
         end
      end else if (fifo_in_ready) begin
         if (ld_idx_ff == ld_last_ff) begin
            ld_active_ff <= 1'b0;
         end else begin
            ld_idx_ff <= ld_idx_ff + 8'h01;
         end
      end
   end

   // group done once loader, fifo and engine are all quiet
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         group_done_out <= 1'b0;
         busy_out       <= 1'b0;
      end else begin
         busy_out <= (state_ff != `ST_IDLE) | ld_active_ff | fifo_out_valid;
         if (!ld_active_ff && !fifo_out_valid && state_ff == `ST_IDLE && !group_start_in) begin
            group_done_out <= busy_out;
         end else if (group_start_in) begin
            group_done_out <= 1'b0;
         end
      end
   end

   // ****************************************
   // per word format
   // ****************************************

   // control field picks one of two formats
   assign sel_fmt    = fifo_out_data[16 + `CTRL_FMT_SEL_BIT] ? word_format1_reg_in
                                                               : word_format0_reg_in;
   assign new_len    = eff_len(sel_fmt[`FMT_LEN_MSB:`FMT_LEN_LSB]);
   assign new_period = sclk_period(sel_fmt[`FMT_PS_MSB:`FMT_PS_LSB]);
   assign new_half_a = new_period[8:1];

   // start of a word: controller on a queued word, peripheral on select
   assign fifo_pop = (state_ff == `ST_IDLE) & fifo_out_valid &
                     (ctrl_mode | ~chip_select_n_in);

   // ****************************************
   // edge events
   // ****************************************

   // first edge of phase-clear word ends the lead
   assign do_edge_c = ctrl_mode & (cnt_ff == 9'd0) &
                      ((state_ff == `ST_SHIFT) | ((state_ff == `ST_LEAD) & ~pha_ff));
   // peripheral edges come from the pin
   assign do_edge_p = ~ctrl_mode & (state_ff == `ST_SHIFT) & ~chip_select_n_in &
                      (serial_clock_pin_in != sclk_prev_ff);
   assign do_edge   = do_edge_c | do_edge_p;
   assign is_sample = pha_ff ? ecnt_ff[0] : ~ecnt_ff[0];
   assign is_shift  = pha_ff ? (~ecnt_ff[0] & (ecnt_ff != 6'd0)) : ecnt_ff[0];
   // incoming bit taken on the sampling edge
   assign din       = ctrl_mode ? controller_in_line_in : controller_out_line_in;
   assign last_sample = is_sample & ({3'b000, ecnt_ff[5:1]} + 5'd1 == len_ff);

   // write back into the entry just finished
   assign hw_we   = (state_ff == `ST_DONE);
   assign hw_stat = {14'h0000, abort_ff, 1'b1};

   // ****************************************
   // shift engine
   // ****************************************
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_ff     <= `ST_IDLE;
         sh_ff        <= 16'h0000;
         rx_ff        <= 16'h0000;
         idx_ff       <= 8'h00;
         len_ff       <= `WORD_LEN_MIN;
         pol_ff       <= 1'b0;
         pha_ff       <= 1'b0;
         hold_ff      <= 1'b0;
         half_a_ff    <= 8'h01;
         half_b_ff    <= 8'h01;
         cnt_ff       <= 9'd0;
         ecnt_ff      <= 6'd0;
         sclk_ff      <= 1'b0;
         cs_n_ff      <= `RST_CS_N;
         abort_ff     <= 1'b0;
         sclk_prev_ff <= 1'b0;
      end else begin
         sclk_prev_ff <= serial_clock_pin_in;
         case (state_ff)
            `ST_IDLE: begin
               sclk_ff  <= word_format0_reg_in[`FMT_POLARITY_BIT];
               abort_ff <= 1'b0;
               if (fifo_pop) begin
                  idx_ff    <= fifo_out_data[39:32];
                  len_ff    <= new_len;
                  pol_ff    <= sel_fmt[`FMT_POLARITY_BIT];
                  pha_ff    <= sel_fmt[`FMT_PHASE_BIT];
                  hold_ff   <= fifo_out_data[16 + `CTRL_HOLD_BIT];
                  half_a_ff <= new_half_a;
                  half_b_ff <= new_period[7:0] - new_half_a;
                  sclk_ff   <= sel_fmt[`FMT_POLARITY_BIT];
                  // left align the word, msb first
                  sh_ff     <= fifo_out_data[15:0] << (5'd16 - new_len);
                  rx_ff     <= 16'h0000;
                  ecnt_ff   <= 6'd0;
                  if (ctrl_mode) begin
                     // lead of delay plus 2, one more with hold
                     cs_n_ff  <= 1'b0;
                     cnt_ff   <= {1'b0, select_lead_delay_in} + `LEAD_BASE - 9'd1 +
                                 {8'h00, fifo_out_data[16 + `CTRL_HOLD_BIT]};
                     state_ff <= `ST_LEAD;
                  end else begin
                     state_ff <= `ST_SHIFT;
                  end
               end else begin
                  cs_n_ff <= `RST_CS_N;
               end
            end
            `ST_LEAD: begin
               if (cnt_ff != 9'd0) begin
                  cnt_ff <= cnt_ff - 9'd1;
               end else begin
                  // phase set waits half a period before launch edge
                  if (pha_ff) begin
                     cnt_ff <= {1'b0, half_a_ff} - 9'd1;
                  end
                  state_ff <= `ST_SHIFT;
               end
            end
            `ST_SHIFT: begin
               if (ctrl_mode && cnt_ff != 9'd0) begin
                  cnt_ff <= cnt_ff - 9'd1;
               end
               if (!ctrl_mode && chip_select_n_in) begin
                  // select dropped mid word
                  abort_ff <= 1'b1;
                  state_ff <= `ST_DONE;
               end
            end
            `ST_LAG: begin
               if (cnt_ff != 9'd0) begin
                  cnt_ff <= cnt_ff - 9'd1;
               end else begin
                  // release unless hold keeps select for the next word
                  if (!hold_ff || !fifo_out_valid) begin
                     cs_n_ff <= 1'b1;
                  end
                  state_ff <= `ST_DONE;
               end
            end
            `ST_DONE: begin
               state_ff <= `ST_IDLE;
            end
            default: begin
               state_ff <= `ST_IDLE;
            end
         endcase

         // one serial edge: sample, shift, count, reload half period
         if (do_edge) begin
            ecnt_ff <= ecnt_ff + 6'd1;
            if (is_sample) begin
               rx_ff <= {rx_ff[14:0], din};
            end
            if (is_shift) begin
               // next bit driven on the non-sampling edge
               sh_ff <= {sh_ff[14:0], 1'b0};
            end
            if (ctrl_mode) begin
               sclk_ff  <= ~sclk_ff;
               cnt_ff   <= (ecnt_ff[0] ? {1'b0, half_a_ff} : {1'b0, half_b_ff}) - 9'd1;
               state_ff <= `ST_SHIFT;
               if (ecnt_ff == {len_ff, 1'b0} - 6'd1) begin
                  // lag of half a period plus delay plus 1
                  cnt_ff   <= {1'b0, half_a_ff} + {1'b0, select_lag_delay_in} +
                              `LAG_BASE - 9'd1;
                  state_ff <= `ST_LAG;
               end
            end else if (last_sample) begin
               state_ff <= `ST_DONE;
            end
         end
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************

   // per pin software override, else serial function
   always @(posedge clk_in) begin
      if (sys_rst_in) begin
         serial_clock_pin_out       <= 1'b0;
         serial_clock_pin_oe_out    <= 1'b0;
         controller_out_line_out    <= 1'b0;
         controller_out_line_oe_out <= 1'b0;
         controller_in_line_out     <= 1'b0;
         controller_in_line_oe_out  <= 1'b0;
         chip_select_n_out          <= `RST_CS_N;
         chip_select_n_oe_out       <= 1'b0;
         gpio_din_out               <= 4'h0;
      end else begin
         gpio_din_out <= {chip_select_n_in, controller_in_line_in,
                          controller_out_line_in, serial_clock_pin_in};
         // clock driven only in controller mode
         serial_clock_pin_out    <= gpio_en_in[0] ? gpio_dout_in[0] : sclk_ff;
         serial_clock_pin_oe_out <= gpio_en_in[0] ? gpio_dir_in[0] : ctrl_mode;
         controller_out_line_out    <= gpio_en_in[1] ? gpio_dout_in[1] : sh_ff[15];
         controller_out_line_oe_out <= gpio_en_in[1] ? gpio_dir_in[1] : ctrl_mode;
         controller_in_line_out    <= gpio_en_in[2] ? gpio_dout_in[2] : sh_ff[15];
         controller_in_line_oe_out <= gpio_en_in[2] ? gpio_dir_in[2] :
                                      (~ctrl_mode & ~chip_select_n_in);
         chip_select_n_out    <= gpio_en_in[3] ? gpio_dout_in[3] : cs_n_ff;
         chip_select_n_oe_out <= gpio_en_in[3] ? gpio_dir_in[3] : ctrl_mode;
      end
   end
endmodule // multibuffer_serial_port
`default_nettype wire

// ==== dv/serial_peer_model.sv ====
// far-side device model that echoes the controller-out line while selected, else drives the inverted last bit
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
   input  wire logic clk_in,
   input  wire logic chip_select_n_in,
   input  wire logic data_in,
   output var  logic data_out
);
   logic last_ff = 1'b0;
   // last bit seen on the line
   always @(posedge clk_in) last_ff <= data_in;
   assign data_out = chip_select_n_in ? ~last_ff : data_in;
endmodule // serial_peer_model
`default_nettype wire

// ==== dv/multibuffer_serial_port_monitor.sv ====
// pin-level assertions for the buffered serial port
`timescale 1ns/1ps
`default_nettype none
module multibuffer_serial_port_monitor (
   input wire logic        clk_in, sys_rst_in, group_start_in, busy_out, group_done_out,
   input wire logic        serial_clock_pin_in, controller_out_line_in, controller_in_line_in,
   input wire logic        chip_select_n_in, serial_clock_pin_out, serial_clock_pin_oe_out,
   input wire logic        chip_select_n_out, chip_select_n_oe_out,
   input wire logic [31:0] global_control_reg_in,
   input wire logic [7:0]  select_lead_delay_in, select_lag_delay_in,
   input wire logic [3:0]  gpio_en_in, gpio_din_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [9:0] low_ff, quiet_ff;
   logic       seen_ff, sclk_ff;
   wire        ctl = global_control_reg_in[0] && gpio_en_in == 4'h0;
   wire        edge_w = serial_clock_pin_out != sclk_ff;
   // cycles since select fell and since the last clock change
   always_ff @(posedge clk_in) begin
      sclk_ff  <= serial_clock_pin_out;
      low_ff   <= chip_select_n_out ? 10'h000 : low_ff + 10'h001;
      seen_ff  <= !chip_select_n_out && (seen_ff || edge_w);
      quiet_ff <= (edge_w || sys_rst_in) ? 10'h000 : quiet_ff + 10'h001;
   end
   sequence s_start;
      group_start_in && !busy_out;
   endsequence
   AST_GPIO_IN:
      assert property (!$past(sys_rst_in) |-> gpio_din_out == $past({chip_select_n_in,
         controller_in_line_in, controller_out_line_in, serial_clock_pin_in}))
      else $error("pin inputs not mirrored");
   AST_PERI_CLK:
      assert property (!global_control_reg_in[0] && !gpio_en_in[0] |=> !serial_clock_pin_oe_out)
      else $error("clock driven in peripheral mode");
   AST_LEAD:
      assert property (ctl && edge_w && !seen_ff && !chip_select_n_out
         |-> low_ff >= select_lead_delay_in + 10'd2) else $error("select lead too short");
   AST_LAG:
      assert property (ctl && $rose(chip_select_n_out) |-> quiet_ff >= select_lag_delay_in + 10'd1)
      else $error("select lag too short");
   AST_IDLE_CS:
      assert property (!busy_out && !gpio_en_in[3] |-> chip_select_n_out)
      else $error("select active while idle");
   AST_DONE_QUIET:
      assert property (group_done_out |-> !busy_out && chip_select_n_out)
      else $error("done while busy");
   AST_BUSY_START:
      assert property (s_start |-> ##[1:3] busy_out) else $error("group did not start");
   AST_RST:
      assert property (disable iff (1'b0) sys_rst_in |=> chip_select_n_out && !busy_out
         && !group_done_out && !serial_clock_pin_oe_out) else $error("bad reset state");
endmodule // multibuffer_serial_port_monitor
bind multibuffer_serial_port multibuffer_serial_port_monitor u_mon (.*);
`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the buffered serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_in = 1'b0, sys_rst_in = 1'b1, buf_wr_en_in = 1'b0, group_start_in = 1'b0;
   logic        clr = 1'b0;
   logic [31:0] gcr = 32'h0, fmt0 = 32'h0, fmt1 = 32'h0;
   logic [7:0]  wa = 8'h00, ra = 8'h00, first = 8'h00, last = 8'h00;
   logic [15:0] tx = 16'h0000, ctrl = 16'h0000;
   logic [3:0]  gen = 4'h0, gdir = 4'h0, gdo = 4'h0;
   wire  [15:0] rx, st;
   wire  [3:0]  gdi;
   wire         sck, sck_oe, co, co_oe, ci, ci_oe, cs, cs_oe, miso, busy, done;
   wire         sck_w = sck_oe ? sck : 1'b0;
   wire         co_w = co_oe ? co : 1'b0;
   wire         ci_w = ci_oe ? ci : miso;
   wire         cs_w = cs_oe ? cs : 1'b1;
   int          err_count = 0, checked = 0;
   always #50 clk_in = ~clk_in;
   multibuffer_serial_port u_dut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .global_control_reg_in(gcr),
      .word_format0_reg_in(fmt0), .word_format1_reg_in(fmt1),
      .select_lead_delay_in(8'h03), .select_lag_delay_in(8'h02),
      .buf_wr_en_in(buf_wr_en_in), .buf_wr_addr_in(wa), .buf_wr_tx_in(tx),
      .buf_wr_ctrl_in(ctrl), .buf_rd_addr_in(ra), .buf_stat_clr_in(clr),
      .buf_rd_rx_out(rx), .buf_rd_stat_out(st), .group_first_in(first),
      .group_last_in(last), .group_start_in(group_start_in), .gpio_en_in(gen),
      .gpio_dir_in(gdir), .gpio_dout_in(gdo), .gpio_din_out(gdi),
      .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck), .serial_clock_pin_oe_out(sck_oe),
      .controller_out_line_in(co_w), .controller_out_line_out(co),
      .controller_out_line_oe_out(co_oe), .controller_in_line_in(ci_w),
      .controller_in_line_out(ci), .controller_in_line_oe_out(ci_oe),
      .chip_select_n_in(cs_w), .chip_select_n_out(cs), .chip_select_n_oe_out(cs_oe),
      .busy_out(busy), .group_done_out(done));
   serial_peer_model u_peer (.clk_in(clk_in), .chip_select_n_in(cs_w), .data_in(co_w),
      .data_out(miso));
   // compare, verdict and bus helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("errors=%0d checks=%0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [15:0] c);
      buf_wr_en_in <= 1'b1;
      wa <= a;
      tx <= d;
      ctrl <= c;
      @(posedge clk_in);
      buf_wr_en_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic run(input logic [7:0] f, input logic [7:0] l);
      first <= f;
      last <= l;
      group_start_in <= 1'b1;
      @(posedge clk_in);
      group_start_in <= 1'b0;
      for (int i = 0; i <= 20000; i++) begin
         @(negedge clk_in);
         if (i == 20000) begin
            err_count++;
            stop_test();
         end
         if (done === 1'b1 && i > 2) break;
      end
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] erx);
      ra <= a;
      @(posedge clk_in);
      @(negedge clk_in);
      chk(rx, erx);
      chk(st, 16'h0001);
      @(posedge clk_in);
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      @(posedge clk_in);
      @(negedge clk_in);
      chk(st, 16'h0000);
      @(posedge clk_in);
   endtask
   // two words of differing formats, held select between them
   task automatic t_words(input logic pol);
      fmt0 <= {14'h0, pol, 1'b0, 8'h03, 8'h08};
      fmt1 <= {14'h0, pol, 1'b1, 8'h05, 8'h10};
      wr(8'h10, 16'ha5a5, 16'h0002);
      wr(8'h11, 16'hbeef, 16'h0001);
      run(8'h10, 8'h11);
      rd(8'h10, 16'ha5a5 & 16'h00ff);
      rd(8'h11, 16'hbeef);
   endtask
   // shortest word and a group wrapping past the top entry
   task automatic t_short;
      fmt0 <= {16'h0000, 8'h07, 8'h02};
      fmt1 <= {16'h0001, 8'h04, 8'h05};
      wr(8'hff, 16'hc003, 16'h0000);
      wr(8'h00, 16'hb016, 16'h0001);
      run(8'hff, 8'h00);
      rd(8'hff, 16'hc003 & 16'h0003);
      rd(8'h00, 16'hb016 & 16'h001f);
   endtask
   // all four pins overridden as outputs
   task automatic t_gpio;
      gcr <= 32'h0;
      gen <= 4'hf;
      gdir <= 4'hf;
      gdo <= 4'b1010;
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
      chk({12'h0, cs, ci, co, sck}, 16'h000a);
      chk({12'h0, cs_oe, ci_oe, co_oe, sck_oe}, 16'h000f);
      chk({12'h0, gdi}, 16'h000a);
      @(posedge clk_in);
      gen <= 4'h0;
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      gcr <= 32'h1;
      @(posedge clk_in);
      t_words(1'b0);
      t_words(1'b1);
      t_short();
      t_gpio();
      repeat (2) @(posedge clk_in);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
